// file: frig_irq_model.sv
/*
  Interrupt controller side: edge-detected pending flag, enable, priority level.
  Assumes the request is a one-cycle active-high pulse on pclk.
*/
`timescale 1ns/100ps
module frig_irq_model #(
  parameter logic [7:0] IRQ_LEVEL = 8'h01
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Request and software controls
  input  wire logic irq_req,
  input  wire logic clr_pend,
  input  wire logic irq_en,
  // Observed state
  output logic      pending,
  output logic      cpu_irq,
  output int        edge_count
);
  logic req_q;
  // ==========================================================
  // Edge detect: a level held high counts only once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q      <= 1'b0;
      pending    <= 1'b0;
      edge_count <= 0;
    end else begin
      req_q <= irq_req;
      if (irq_req && !req_q) begin
        pending    <= 1'b1;
        edge_count <= edge_count + 1;
      end else if (clr_pend) begin
        pending <= 1'b0;
      end
    end
  end
  // CPU path only; no transfer or standby wake outputs
  assign cpu_irq = pending && irq_en && (IRQ_LEVEL != 8'h00);
endmodule : frig_irq_model

// file: frig_pkg.sv
/*
  Constants and state types for the flash ready interrupt and plane guard.
  Assumes a 32-bit APB register bus and a single system clock.
*/
// What this block does
// RULE1 - Ready interrupt uses vector 23, offset 005Ch, edge detected.
// RULE2 - Ready interrupt is a CPU interrupt only; no transfer or standby wake.
// RULE3 - Ready interrupt fires when a command or forced stop completes, all areas.
// RULE4 - Main ready flag sets on completion; cleared by writing start bit 0.
// RULE5 - Extra-area ready flag sets on extra command completion; cleared by start 0.
// RULE6 - Interrupt request is deasserted once a ready flag has returned to 0.
// RULE7 - Software clears pending flag before enabling the interrupt.
// RULE8 - Code flash is at most 512 Kbytes.
// RULE9 - Above 256 Kbytes the flash splits into two planes at 256 Kbytes.
// RULE10 - Planes consist of 1-Kbyte blocks, at most 256 per plane.
// RULE11 - Block erase erases whole 1-Kbyte blocks.
// RULE12 - Blank check or block erase never spans a plane boundary.
// RULE13 - Software keeps start and end address in one plane.
// RULE14 - Block erase covers start block through end block in one plane.
// RULE15 - Interrupt is one edge per rise of either ready flag; rises of both flags in the same or the next cycle give one edge.
package frig_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] OFS_CMD_CTRL   = 8'h00;
  localparam logic [7:0] OFS_EXT_CTRL   = 8'h04;
  localparam logic [7:0] OFS_START_ADDR = 8'h08;
  localparam logic [7:0] OFS_END_ADDR   = 8'h0c;
  localparam logic [7:0] OFS_STATUS     = 8'h10;
  localparam logic [7:0] OFS_IRQ_INFO   = 8'h14;

  // ==========================================================
  // Field positions
  localparam int BIT_START     = 0;
  localparam int BIT_CODE_LO   = 1;
  localparam int BIT_FORCE     = 3;
  localparam int BIT_ST_MAIN   = 0;
  localparam int BIT_ST_EXT    = 1;
  localparam int BIT_ST_BUSY   = 2;
  localparam int BIT_ST_EXBUSY = 3;
  localparam int BIT_ST_RANGE  = 4;

  // ==========================================================
  // Interrupt identity
  localparam logic [7:0]  IRQ_VECTOR_NUM = 8'h17;   // 23
  localparam logic [15:0] IRQ_VECTOR_OFS = 16'h005c;

  // ==========================================================
  // Flash geometry
  localparam int ADDR_W         = 19;
  localparam int BLOCK_BYTES    = 1024;
  localparam int BLK_W          = 9;
  localparam int PLANE_KB       = 256;
  localparam int MAX_FLASH_KB   = 512;
  localparam int BLKS_PER_PLANE = 256;

  // ==========================================================
  // Timing and reset values
  localparam logic [7:0]  STEP_CYCLES  = 8'h10;
  localparam logic [7:0]  EXT_CYCLES   = 8'h08;
  localparam logic [31:0] RESET_WORD   = 32'h0000_0000;

  typedef enum logic [1:0] {
    FRIG_CMD_NONE  = 2'h0,
    FRIG_CMD_BLANK = 2'h1,
    FRIG_CMD_ERASE = 2'h2,
    FRIG_CMD_OTHER = 2'h3
  } frig_cmd_type;

  typedef enum logic [2:0] {
    FRIG_IDLE = 3'b001,
    FRIG_WALK = 3'b010,
    FRIG_DONE = 3'b100
  } frig_state_type;

endpackage : frig_pkg

// file: frig_plane_guard.sv
/*
  Plane guard: maps the programmed address pair onto plane and block numbers
  and flags any range that leaves one plane or the populated flash.
  Assumes registered address inputs; purely combinational.
*/
`timescale 1ns/100ps
module frig_plane_guard #(
  parameter int FLASH_KB = frig_pkg::MAX_FLASH_KB
) (
  // Range request and result
  frig_range_if.guard rng
);
  localparam int  OFS_W      = $clog2(frig_pkg::BLOCK_BYTES);
  localparam bit  TWO_PLANES = FLASH_KB > frig_pkg::PLANE_KB;  // see RULE9
  localparam logic [frig_pkg::ADDR_W:0] LIMIT = (frig_pkg::ADDR_W+1)'(FLASH_KB * 1024);

  if (FLASH_KB > frig_pkg::MAX_FLASH_KB || FLASH_KB < 1) begin : g_size_chk  // see RULE8
    $error("FLASH_KB outside 1..512");
  end

  logic plane_differs;

  // Block number: top bit is the plane, low eight bits the block in it
  assign rng.start_blk = rng.start_addr[frig_pkg::ADDR_W-1:OFS_W];  // see RULE10
  assign rng.end_blk   = rng.end_addr[frig_pkg::ADDR_W-1:OFS_W];    // see RULE10

  assign plane_differs = TWO_PLANES &&
                         (rng.start_addr[frig_pkg::ADDR_W-1] != rng.end_addr[frig_pkg::ADDR_W-1]);

  // Crossing the 256 Kbyte line is refused outright
  assign rng.range_bad = plane_differs  // see RULE12
                      || (rng.start_blk > rng.end_blk)
                      || ({1'b0, rng.end_addr} >= LIMIT);
endmodule : frig_plane_guard

// file: frig_range_if.sv
/*
  Carrier between the sequencer and its plane guard.
  Assumes both ends sit in the same clock domain.
*/
`timescale 1ns/100ps
interface frig_range_if;
  logic [frig_pkg::ADDR_W-1:0] start_addr;
  logic [frig_pkg::ADDR_W-1:0] end_addr;
  logic [frig_pkg::BLK_W-1:0]  start_blk;
  logic [frig_pkg::BLK_W-1:0]  end_blk;
  logic                        range_bad;

  modport guard (input start_addr, end_addr, output start_blk, end_blk, range_bad);
  modport user  (output start_addr, end_addr, input start_blk, end_blk, range_bad);
endinterface : frig_range_if

// file: frig_sequencer.sv
/*
  Flash command sequencer core: APB registers, block walk for blank check
  and block erase, extra-area commands, ready flags and the ready interrupt.
  Assumes a zero-wait APB master on pclk and a flash array that acts on
  one block strobe at a time.
*/
`timescale 1ns/100ps
module frig_sequencer #(
  parameter int FLASH_KB = frig_pkg::MAX_FLASH_KB
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Flash array strobes
  output logic             erase_blk_stb,
  output logic             check_blk_stb,
  output logic [8:0]       blk_index,
  // Interrupt controller
  output logic             flash_done_irq
);

  if (FLASH_KB > frig_pkg::MAX_FLASH_KB) begin : g_size_chk  // see RULE8
    $error("Flash larger than 512 Kbytes");
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic                       cmd_start;
    frig_pkg::frig_cmd_type     cmd_code;
    logic                       ext_start;
    logic [frig_pkg::ADDR_W-1:0] start_addr;
    logic [frig_pkg::ADDR_W-1:0] end_addr;
    frig_pkg::frig_state_type   st;
    logic                       main_rdy;
    logic                       ext_rdy;
    logic                       ext_busy;
    logic                       range_err;
    logic [8:0]                 cur_blk;
    logic [8:0]                 last_blk;
    logic [7:0]                 cnt;
    logic [7:0]                 ext_cnt;
    logic                       irq;
    logic                       erase_stb;
    logic                       check_stb;
    logic [8:0]                 blk;
    logic [31:0]                rdata;
    logic                       ready;
    logic                       slverr;
  } frig_seq_type;

  frig_seq_type q;
  frig_seq_type d;

  frig_range_if rng ();

  frig_plane_guard #(
    .FLASH_KB (FLASH_KB)
  ) u_guard (
    .rng (rng.guard)
  );

  assign rng.start_addr = q.start_addr;
  assign rng.end_addr   = q.end_addr;

  // ==========================================================
  // Decode
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == frig_pkg::OFS_CMD_CTRL)   || (a == frig_pkg::OFS_EXT_CTRL)
          || (a == frig_pkg::OFS_START_ADDR) || (a == frig_pkg::OFS_END_ADDR)
          || (a == frig_pkg::OFS_STATUS)     || (a == frig_pkg::OFS_IRQ_INFO);
  endfunction : mapped

  logic setup_ph;
  logic wr_acc;
  logic wr_cmd;
  logic wr_ext;
  logic main_done;
  logic ext_done;
  logic force_stop;

  assign setup_ph   = psel && !penable;
  assign wr_acc     = psel && penable && q.ready && pwrite && !q.slverr;
  assign wr_cmd     = wr_acc && (paddr == frig_pkg::OFS_CMD_CTRL);
  assign wr_ext     = wr_acc && (paddr == frig_pkg::OFS_EXT_CTRL);
  assign force_stop = wr_cmd && pwdata[frig_pkg::BIT_FORCE] && (q.st != frig_pkg::FRIG_IDLE);

  always_comb begin
    d = q;
    d.erase_stb = 1'b0;
    d.check_stb = 1'b0;
    main_done   = 1'b0;
    ext_done    = 1'b0;

    // APB answer is prepared in setup so it comes from a flop in access
    d.ready  = setup_ph;
    d.slverr = setup_ph && !mapped(paddr);
    d.rdata  = frig_pkg::RESET_WORD;
    if (setup_ph && !pwrite) begin
      unique case (paddr)
        frig_pkg::OFS_CMD_CTRL:   d.rdata = {28'h0000000, 1'b0, q.cmd_code, q.cmd_start};
        frig_pkg::OFS_EXT_CTRL:   d.rdata = {31'h00000000, q.ext_start};
        frig_pkg::OFS_START_ADDR: d.rdata = {13'h0000, q.start_addr};
        frig_pkg::OFS_END_ADDR:   d.rdata = {13'h0000, q.end_addr};
        frig_pkg::OFS_STATUS:     d.rdata = {27'h0000000, q.range_err, q.ext_busy,
                                             q.st != frig_pkg::FRIG_IDLE, q.ext_rdy, q.main_rdy};
        frig_pkg::OFS_IRQ_INFO:   d.rdata = {8'h00, frig_pkg::IRQ_VECTOR_OFS,
                                             frig_pkg::IRQ_VECTOR_NUM};  // see RULE1
        default:                  d.rdata = frig_pkg::RESET_WORD;
      endcase
    end

    // Address registers are locked while a walk runs
    if (wr_acc && (q.st == frig_pkg::FRIG_IDLE)) begin
      if (paddr == frig_pkg::OFS_START_ADDR) d.start_addr = pwdata[frig_pkg::ADDR_W-1:0];
      if (paddr == frig_pkg::OFS_END_ADDR)   d.end_addr   = pwdata[frig_pkg::ADDR_W-1:0];
    end

    // ==========================================================
    // Main command walk
    unique case (q.st)
      frig_pkg::FRIG_IDLE: begin
        if (wr_cmd && pwdata[frig_pkg::BIT_START] && !q.cmd_start) begin
          d.cmd_code  = frig_pkg::frig_cmd_type'(pwdata[frig_pkg::BIT_CODE_LO +: 2]);
          d.cur_blk   = rng.start_blk;
          d.last_blk  = rng.end_blk;
          d.cnt       = frig_pkg::STEP_CYCLES;
          d.range_err = 1'b0;
          d.st        = frig_pkg::FRIG_WALK;
          // A range that leaves its plane is refused before any block moves
          if ((d.cmd_code == frig_pkg::FRIG_CMD_BLANK || d.cmd_code == frig_pkg::FRIG_CMD_ERASE)
              && rng.range_bad) begin  // see RULE12
            d.range_err = 1'b1;
            d.st        = frig_pkg::FRIG_DONE;
          end
        end
      end
      frig_pkg::FRIG_WALK: begin
        if (q.cnt != 8'h00) begin
          d.cnt = q.cnt - 8'h01;
        end else if (q.cmd_code == frig_pkg::FRIG_CMD_BLANK ||
                     q.cmd_code == frig_pkg::FRIG_CMD_ERASE) begin
          d.erase_stb = (q.cmd_code == frig_pkg::FRIG_CMD_ERASE);  // see RULE11
          d.check_stb = (q.cmd_code == frig_pkg::FRIG_CMD_BLANK);
          d.blk       = q.cur_blk;
          d.cnt       = frig_pkg::STEP_CYCLES;
          d.cur_blk   = q.cur_blk + 9'h001;
          if (q.cur_blk == q.last_blk) d.st = frig_pkg::FRIG_DONE;  // see RULE14
        end else begin
          d.st = frig_pkg::FRIG_DONE;
        end
        if (force_stop) d.st = frig_pkg::FRIG_DONE;
      end
      frig_pkg::FRIG_DONE: begin
        main_done = 1'b1;  // see RULE3
        d.st      = frig_pkg::FRIG_IDLE;
      end
    endcase

    // Start bit follows software; the walk only begins on its rise
    if (wr_cmd) d.cmd_start = pwdata[frig_pkg::BIT_START];
    if (wr_ext) d.ext_start = pwdata[frig_pkg::BIT_START];

    // ==========================================================
    // Extra-area command
    if (!q.ext_busy && wr_ext && pwdata[frig_pkg::BIT_START] && !q.ext_start) begin
      d.ext_busy = 1'b1;
      d.ext_cnt  = frig_pkg::EXT_CYCLES;
    end else if (q.ext_busy) begin
      if (q.ext_cnt == 8'h00) begin
        d.ext_busy = 1'b0;
        ext_done   = 1'b1;
      end else begin
        d.ext_cnt = q.ext_cnt - 8'h01;
      end
    end

    // ==========================================================
    // Ready flags: completion wins over a clear in the same cycle
    if (wr_cmd && !pwdata[frig_pkg::BIT_START]) d.main_rdy = 1'b0;  // see RULE4
    if (main_done) d.main_rdy = 1'b1;                                // see RULE4
    if (wr_ext && !pwdata[frig_pkg::BIT_START]) d.ext_rdy = 1'b0;   // see RULE5
    if (ext_done) d.ext_rdy = 1'b1;                                  // see RULE5

    // Request is high in the same cycle in which either flag first reads 1; a flag held at 1 requests nothing more
    d.irq = (d.main_rdy && !q.main_rdy) || (d.ext_rdy && !q.ext_rdy);  // see RULE6, RULE15
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q          <= '0;
      q.cmd_code <= frig_pkg::FRIG_CMD_NONE;
      q.st       <= frig_pkg::FRIG_IDLE;
    end else begin
      q <= d;
    end
  end

  // Only a CPU line: no transfer trigger or standby wake is provided
  assign flash_done_irq = q.irq;  // see RULE2
  assign prdata         = q.rdata;
  assign pready         = q.ready;
  assign pslverr        = q.slverr;
  assign erase_blk_stb  = q.erase_stb;
  assign check_blk_stb  = q.check_stb;
  assign blk_index      = q.blk;

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence main_rise_s;
    !q.main_rdy ##1 q.main_rdy;
  endsequence

  sequence ext_rise_s;
    !q.ext_rdy ##1 q.ext_rdy;
  endsequence

  irq_on_main_a: assert property (main_rise_s |-> flash_done_irq)  // see RULE4
    else $error("No interrupt on main ready rise");
  irq_on_ext_a: assert property (ext_rise_s |-> flash_done_irq)  // see RULE5
    else $error("No interrupt on extra ready rise");
  irq_single_a: assert property (flash_done_irq |=> !flash_done_irq)  // see RULE15
    else $error("Interrupt longer than one cycle");
  irq_cause_a: assert property (flash_done_irq |->
      ($rose(q.main_rdy) || $rose(q.ext_rdy)))  // see RULE1
    else $error("Interrupt without a flag rise");
  irq_held_low_a: assert property ((!q.main_rdy && !q.ext_rdy) |-> !flash_done_irq)  // see RULE6
    else $error("Interrupt with both flags low");
  done_sets_main_a: assert property (q.st == frig_pkg::FRIG_DONE |=> q.main_rdy)  // see RULE3
    else $error("Completion did not set main ready");
  clear_main_a: assert property ((wr_cmd && !pwdata[0] && q.st != frig_pkg::FRIG_DONE)
      |=> !q.main_rdy)  // see RULE4
    else $error("Start bit 0 did not clear main ready");
  ext_done_a: assert property ((!q.ext_busy && wr_ext && pwdata[0] && !q.ext_start)
      |-> ##[1:12] q.ext_rdy)  // see RULE5
    else $error("Extra command never completed");
  one_plane_a: assert property ((erase_blk_stb || check_blk_stb) |->
      (FLASH_KB <= frig_pkg::PLANE_KB || blk_index[8] == q.start_addr[18]))  // see RULE12
    else $error("Block strobe outside start plane");
  erase_range_a: assert property (erase_blk_stb |->
      (blk_index >= q.start_addr[18:10] && blk_index <= q.end_addr[18:10]))  // see RULE14
    else $error("Erase outside programmed range");
  refuse_cross_a: assert property ((q.st == frig_pkg::FRIG_IDLE && $past(q.st) == q.st &&
      q.range_err) |-> !erase_blk_stb)  // see RULE12
    else $error("Refused range still erased");

endmodule : frig_sequencer

// file: tb_top.sv
/*
  Testbench: APB tasks and command scenarios for the flash ready sequencer.
  Assumes frig_pkg and frig_irq_model are compiled first.
*/
`timescale 1ns/100ps
module tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        erase_blk_stb;
  logic        check_blk_stb;
  logic [8:0]  blk_index;
  logic        flash_done_irq;
  logic        clr_pend;
  logic        irq_en;
  logic        pending;
  logic        cpu_irq;
  int          edge_count;
  int          n_errors;
  int          cmp_count;
  int          cycles;
  int          base;
  logic [9:0]  blks[$];
  logic [31:0] rd;
  logic        rd_err;

  frig_sequencer frig_sequencer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .erase_blk_stb(erase_blk_stb),
    .check_blk_stb(check_blk_stb), .blk_index(blk_index), .flash_done_irq(flash_done_irq));
  frig_irq_model frig_irq_model_inst (.pclk(pclk), .presetn(presetn),
    .irq_req(flash_done_irq), .clr_pend(clr_pend), .irq_en(irq_en), .pending(pending),
    .cpu_irq(cpu_irq), .edge_count(edge_count));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ==========================================================
  // Strobe log: erase flag, then block index
  always @(posedge pclk) begin
    if (erase_blk_stb || check_blk_stb) blks.push_back({erase_blk_stb, blk_index});
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors++;
      results();
    end
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Holds the request until pready is sampled high or 50 further clocks pass
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    // A slave that never answers counts as a mismatch
    if (n >= 50) n_errors++;
    rd      = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_flag(input int b);
    int n;
    n  = 0;
    rd = 32'h0;
    while (rd[b] !== 1'b1 && n < 2000) begin
      apb(1'b0, frig_pkg::OFS_STATUS, 32'h0);
      n++;
    end
    if (rd[b] !== 1'b1) n_errors++;
  endtask : wait_flag

  // One command: program range, start, optional force stop, then clear
  task automatic cmd(input logic [18:0] s, input logic [18:0] e, input logic [31:0] c,
                     input logic force_stop, input int nblk, input logic [9:0] first,
                     input logic [31:0] st);
    blks.delete();
    base = edge_count;
    apb(1'b1, frig_pkg::OFS_START_ADDR, {13'h0, s});
    apb(1'b1, frig_pkg::OFS_END_ADDR, {13'h0, e});
    apb(1'b1, frig_pkg::OFS_CMD_CTRL, c);
    if (force_stop) apb(1'b1, frig_pkg::OFS_CMD_CTRL, c | 32'h8);
    wait_flag(frig_pkg::BIT_ST_MAIN);
    check("status done", rd, st);
    check("strobe count", blks.size(), nblk);
    for (int i = 0; i < nblk; i++) check("block", blks[i], first + i);
    check("irq edges", edge_count - base, 1);
    check("cpu irq", {31'h0, cpu_irq}, 32'h1);
    repeat (20) @(posedge pclk);
    check("no repeat", edge_count - base, 1);
    clr_pend <= 1'b1;
    apb(1'b1, frig_pkg::OFS_CMD_CTRL, 32'h0);
    clr_pend <= 1'b0;
    apb(1'b0, frig_pkg::OFS_STATUS, 32'h0);
    // Range error stays until the next start; only the ready flag clears
    check("status clear", rd, st & 32'h10);
  endtask : cmd

  initial begin
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0;
    clr_pend = 1'b0;
    irq_en   = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    cycles   = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, frig_pkg::OFS_IRQ_INFO, 32'h0);
    check("irq info", rd, 32'h0000_5c17);
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped err", {31'h0, rd_err}, 32'h1);
    apb(1'b0, frig_pkg::OFS_STATUS, 32'h0);
    check("status reset", rd, frig_pkg::RESET_WORD);
    // Pending cleared before the enable is set
    clr_pend <= 1'b1;
    @(posedge pclk);
    clr_pend <= 1'b0;
    irq_en   <= 1'b1;
    cmd(19'h00400, 19'h00bff, 32'h5, 1'b0, 2, 10'h201, 32'h1);
    cmd(19'h40000, 19'h403ff, 32'h3, 1'b0, 1, 10'h100, 32'h1);
    cmd(19'h3fc00, 19'h403ff, 32'h5, 1'b0, 0, 10'h0, 32'h11);
    cmd(19'h00000, 19'h3ffff, 32'h5, 1'b1, 0, 10'h0, 32'h1);
    cmd(19'h00000, 19'h00000, 32'h7, 1'b0, 0, 10'h0, 32'h1);
    base = edge_count;
    apb(1'b1, frig_pkg::OFS_EXT_CTRL, 32'h1);
    wait_flag(frig_pkg::BIT_ST_EXT);
    check("extra ready", rd, 32'h2);
    check("extra irq", edge_count - base, 1);
    apb(1'b1, frig_pkg::OFS_EXT_CTRL, 32'h0);
    apb(1'b0, frig_pkg::OFS_STATUS, 32'h0);
    check("extra clear", rd, 32'h0);
    results();
  end
endmodule : tb_top
